// ==== rtl/pll_cfg_pkg.sv ====
// Package: register map, field layout and reset values of the PLL settings
package pll_cfg_pkg;
    // Register offsets on the control port
    localparam logic [7:0] OFS_PREDIV   = 8'h14;
    localparam logic [7:0] OFS_INTEGER  = 8'h15;
    localparam logic [7:0] OFS_FRAC_HI  = 8'h16;
    localparam logic [7:0] OFS_FRAC_LO  = 8'h17;
    localparam logic [7:0] OFS_RMULT    = 8'h18;
    localparam logic [7:0] OFS_DSPDIV   = 8'h1b;
    // Writable bit masks; bits outside read as zero
    localparam logic [7:0] MSK_PREDIV   = 8'h0f;
    localparam logic [7:0] MSK_INTEGER  = 8'h3f;
    localparam logic [7:0] MSK_FRAC_HI  = 8'h3f;
    localparam logic [7:0] MSK_FRAC_LO  = 8'hff;
    localparam logic [7:0] MSK_RMULT    = 8'h0f;
    localparam logic [7:0] MSK_DSPDIV   = 8'h7f;
    // Reset values
    localparam logic [7:0] RST_PREDIV   = 8'h00;
    localparam logic [7:0] RST_INTEGER  = 8'h08;
    localparam logic [7:0] RST_FRAC_HI  = 8'h00;
    localparam logic [7:0] RST_FRAC_LO  = 8'h00;
    localparam logic [7:0] RST_RMULT    = 8'h00;
    localparam logic [7:0] RST_DSPDIV   = 8'h00;
    // Field widths and limits
    localparam int         J_W          = 6;
    localparam int         D_W          = 14;
    localparam int         FRAC_LO_W    = 8;
    localparam int         R_W          = 5;
    localparam int         DIV_W        = 8;
    localparam logic [13:0] D_MAX       = 14'h270f;
    localparam logic [3:0] PREDIV_BAD   = 4'hf;
    localparam logic [5:0] J_BAD        = 6'h00;
endpackage

// ==== rtl/dsp_div_if.sv ====
// Interface: DSP divider ratio in, divided clock enable out
`timescale 1ns/100ps
interface dsp_div_if;
    logic [pll_cfg_pkg::DIV_W-1:0] ratio;
    logic                          tick;
    modport ctrl (output ratio, input tick);
    modport div  (input ratio, output tick);
endinterface

// ==== rtl/dsp_clk_divider.sv ====
// DSP clock divider: one-cycle enable every ratio cycles of mclk
`timescale 1ns/100ps
module dsp_clk_divider (
    input  wire logic mclk,
    input  wire logic srst,
    dsp_div_if.div    dv
);
    logic [pll_cfg_pkg::DIV_W-1:0] cnt;
    logic [pll_cfg_pkg::DIV_W-1:0] last;

    assign last = dv.ratio - 8'h01;

    // Count modulo ratio; a ratio change takes effect at once: the count runs on
    // to the new end, or wraps on the next edge if it already reached or passed it
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt <= 8'h00;
        end else if (cnt >= last) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    // Registered enable, one pulse per period of ratio cycles
    always_ff @(posedge mclk) begin
        if (srst) begin
            dv.tick <= 1'b0;
        end else begin
            dv.tick <= (cnt >= last);
        end
    end

    // Pulses are spaced by exactly two cycles for a steady ratio of two; the ratio
    // must hold over the gap cycle, since the count follows it at once
    property tick_spacing_p;
        @(posedge mclk) disable iff (srst)
        dv.tick && dv.ratio == 8'h02 ##1 dv.ratio == 8'h02
            |-> !dv.tick ##1 dv.tick;
    endproperty
    tick_spacing_a: assert property (tick_spacing_p)
        else $error("divide by two pulse spacing wrong");
endmodule

// ==== rtl/pll_factor_ctrl.sv ====
// PLL factor and DSP divider configuration registers
//
// How it works
// - Six-bit integer field gives J equal to its code, up to 63.
// - Upper fraction bits come from a six-bit field of their own.
// - Lower eight fraction bits join the upper ones to form D.
// - Four-bit code n selects R equal to n plus one.
// - DSP enable divides the source clock by code plus one, 1 to 128.
// - In auto set mode programmed J, D, R, divider are ignored.
// - Pre-divider P is code plus one; all-ones forbidden; auto ignores it.
`timescale 1ns/100ps
module pll_factor_ctrl #(
    parameter logic [5:0]  AUTO_J      = 6'h08,
    parameter logic [13:0] AUTO_D      = 14'h0000,
    parameter logic [4:0]  AUTO_R      = 5'h01,
    parameter logic [4:0]  AUTO_P      = 5'h01,
    parameter logic [7:0]  AUTO_DIV    = 8'h01
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        auto_mode,
    output logic      [5:0]  pll_j,
    output logic      [13:0] pll_d,
    output logic      [4:0]  pll_r,
    output logic      [4:0]  pll_p,
    output logic      [7:0]  dsp_ratio,
    output logic             dsp_clk_en,
    output logic             cfg_illegal
);
    logic [7:0]  pll_predivider_field;
    logic [7:0]  pll_integer_field;
    logic [7:0]  pll_fraction_hi;
    logic [7:0]  pll_fraction_lo;
    logic [7:0]  pll_multiplier_field;
    logic [7:0]  dsp_divider_field;
    logic [13:0] man_d;
    logic [7:0]  next_rdata;
    logic        next_illegal;

    dsp_div_if dv ();

    // Keep only implemented bits so reserved bits store nothing
    function automatic logic [7:0] keep(input logic [7:0] v,
                                        input logic [7:0] m);
        keep = v & m;
    endfunction

    // Register writes, one register per offset
    always_ff @(posedge mclk) begin
        if (srst) begin
            pll_predivider_field <= pll_cfg_pkg::RST_PREDIV;
            pll_integer_field    <= pll_cfg_pkg::RST_INTEGER;
            pll_fraction_hi      <= pll_cfg_pkg::RST_FRAC_HI;
            pll_fraction_lo      <= pll_cfg_pkg::RST_FRAC_LO;
            pll_multiplier_field <= pll_cfg_pkg::RST_RMULT;
            dsp_divider_field    <= pll_cfg_pkg::RST_DSPDIV;
        end else if (reg_wr) begin
            unique case (reg_addr)
                pll_cfg_pkg::OFS_PREDIV: begin
                    pll_predivider_field <=
                        keep(reg_wdata, pll_cfg_pkg::MSK_PREDIV);
                end
                pll_cfg_pkg::OFS_INTEGER: begin
                    pll_integer_field <=
                        keep(reg_wdata, pll_cfg_pkg::MSK_INTEGER);
                end
                pll_cfg_pkg::OFS_FRAC_HI: begin
                    pll_fraction_hi <=
                        keep(reg_wdata, pll_cfg_pkg::MSK_FRAC_HI);
                end
                pll_cfg_pkg::OFS_FRAC_LO: begin
                    pll_fraction_lo <=
                        keep(reg_wdata, pll_cfg_pkg::MSK_FRAC_LO);
                end
                pll_cfg_pkg::OFS_RMULT: begin
                    pll_multiplier_field <=
                        keep(reg_wdata, pll_cfg_pkg::MSK_RMULT);
                end
                pll_cfg_pkg::OFS_DSPDIV: begin
                    dsp_divider_field <=
                        keep(reg_wdata, pll_cfg_pkg::MSK_DSPDIV);
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        unique case (reg_addr)
            pll_cfg_pkg::OFS_PREDIV:  next_rdata = pll_predivider_field;
            pll_cfg_pkg::OFS_INTEGER: next_rdata = pll_integer_field;
            pll_cfg_pkg::OFS_FRAC_HI: next_rdata = pll_fraction_hi;
            pll_cfg_pkg::OFS_FRAC_LO: next_rdata = pll_fraction_lo;
            pll_cfg_pkg::OFS_RMULT:   next_rdata = pll_multiplier_field;
            pll_cfg_pkg::OFS_DSPDIV:  next_rdata = dsp_divider_field;
            default:                  next_rdata = 8'h00;
        endcase
    end

    // Read data is held until the next read strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // D is the high field over the full low byte
    assign man_d = {pll_fraction_hi[5:0], pll_fraction_lo};

    // Effective factors; auto mode substitutes its own settings
    always_ff @(posedge mclk) begin
        if (srst) begin
            pll_j     <= AUTO_J;
            pll_d     <= AUTO_D;
            pll_r     <= AUTO_R;
            pll_p     <= AUTO_P;
            dsp_ratio <= AUTO_DIV;
        end else if (auto_mode) begin
            pll_j     <= AUTO_J;
            pll_d     <= AUTO_D;
            pll_r     <= AUTO_R;
            pll_p     <= AUTO_P;
            dsp_ratio <= AUTO_DIV;
        end else begin
            pll_j     <= pll_integer_field[5:0];
            pll_d     <= man_d;
            pll_r     <= {1'b0, pll_multiplier_field[3:0]} + 5'h01;
            pll_p     <= {1'b0, pll_predivider_field[3:0]} + 5'h01;
            dsp_ratio <= {1'b0, dsp_divider_field[6:0]} + 8'h01;
        end
    end

    // Forbidden codes are flagged only while they are in use; the
    // hardware still applies them, software must avoid them
    assign next_illegal = !auto_mode &&
        (pll_integer_field[5:0] == pll_cfg_pkg::J_BAD ||
         man_d > pll_cfg_pkg::D_MAX ||
         pll_predivider_field[3:0] == pll_cfg_pkg::PREDIV_BAD);

    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_illegal <= 1'b0;
        end else begin
            cfg_illegal <= next_illegal;
        end
    end

    assign dv.ratio   = dsp_ratio;
    assign dsp_clk_en = dv.tick;

    dsp_clk_divider u_div (
        .mclk (mclk),
        .srst (srst),
        .dv   (dv.div)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence wr_to(logic [7:0] a);
        reg_wr && !auto_mode && reg_addr == a ##1 !reg_wr && !auto_mode;
    endsequence

    j_follows_a: assert property (
        wr_to(pll_cfg_pkg::OFS_INTEGER) |=> pll_j == $past(reg_wdata[5:0], 2))
        else $error("J not equal to written code");
    r_plus_one_a: assert property (
        wr_to(pll_cfg_pkg::OFS_RMULT)
            |=> pll_r == {1'b0, $past(reg_wdata[3:0], 2)} + 5'h01)
        else $error("R not code plus one");
    p_plus_one_a: assert property (
        wr_to(pll_cfg_pkg::OFS_PREDIV)
            |=> pll_p == {1'b0, $past(reg_wdata[3:0], 2)} + 5'h01)
        else $error("P not code plus one");
    d_low_byte_a: assert property (
        wr_to(pll_cfg_pkg::OFS_FRAC_LO)
            |=> pll_d[7:0] == $past(reg_wdata, 2))
        else $error("D low byte wrong");
    d_high_bits_a: assert property (
        wr_to(pll_cfg_pkg::OFS_FRAC_HI)
            |=> pll_d[13:8] == $past(reg_wdata[5:0], 2))
        else $error("D high bits wrong");
    div_ratio_a: assert property (
        wr_to(pll_cfg_pkg::OFS_DSPDIV)
            |=> dsp_ratio == {1'b0, $past(reg_wdata[6:0], 2)} + 8'h01)
        else $error("DSP ratio not code plus one");
    auto_ignore_a: assert property (
        auto_mode [*2] |-> pll_j == AUTO_J && pll_r == AUTO_R &&
            pll_d == AUTO_D && dsp_ratio == AUTO_DIV && pll_p == AUTO_P)
        else $error("auto mode used programmed fields");
    reserved_zero_a: assert property (
        reg_rd && reg_addr == pll_cfg_pkg::OFS_INTEGER
            |=> reg_rdata[7:6] == 2'b00)
        else $error("reserved bits read nonzero");
    j_zero_flag_a: assert property (
        !auto_mode && pll_integer_field[5:0] == pll_cfg_pkg::J_BAD
            |=> cfg_illegal)
        else $error("zero J not flagged");
    d_limit_flag_a: assert property (
        !auto_mode && man_d > pll_cfg_pkg::D_MAX
            |=> cfg_illegal)
        else $error("D above limit not flagged");
    p_bad_flag_a: assert property (
        !auto_mode && pll_predivider_field[3:0] == pll_cfg_pkg::PREDIV_BAD
            |=> cfg_illegal)
        else $error("all-ones P code not flagged");
    // A legal setting must clear the flag, or a stuck flag would pass
    legal_clear_a: assert property (
        !auto_mode && pll_integer_field[5:0] != pll_cfg_pkg::J_BAD &&
        man_d <= pll_cfg_pkg::D_MAX &&
        pll_predivider_field[3:0] != pll_cfg_pkg::PREDIV_BAD
            |=> !cfg_illegal)
        else $error("legal setting flagged");
    auto_flag_off_a: assert property (
        auto_mode |=> !cfg_illegal)
        else $error("flag raised in auto mode");
    rdata_hold_a: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule

// ==== tb/pll_factor_ctrl_tb_top.sv ====
// Testbench: register port, effective factors and DSP enable of the PLL block
`timescale 1ns/100ps
module pll_factor_ctrl_tb_top;
    // Auto values differ from every programmed value so a leak shows
    localparam logic [5:0]  A_J   = 6'h11;
    localparam logic [13:0] A_D   = 14'h0123;
    localparam logic [4:0]  A_R   = 5'h03;
    localparam logic [4:0]  A_P   = 5'h02;
    localparam logic [7:0]  A_DIV = 8'h04;
    logic        mclk      = 1'b0;
    logic        srst      = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        auto_mode = 1'b0;
    logic [7:0]  reg_rdata;
    logic [5:0]  pll_j;
    logic [13:0] pll_d;
    logic [4:0]  pll_r;
    logic [4:0]  pll_p;
    logic [7:0]  dsp_ratio;
    logic        dsp_clk_en;
    logic        cfg_illegal;
    int          errors = 0;
    int          checks = 0;
    logic [7:0]  v;
    // Register table in offset order: offset, reset value, writable mask
    logic [7:0] ofs [6] = '{pll_cfg_pkg::OFS_PREDIV, pll_cfg_pkg::OFS_INTEGER,
        pll_cfg_pkg::OFS_FRAC_HI, pll_cfg_pkg::OFS_FRAC_LO,
        pll_cfg_pkg::OFS_RMULT, pll_cfg_pkg::OFS_DSPDIV};
    logic [7:0] rst [6] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk [6] = '{8'h0f, 8'h3f, 8'h3f, 8'hff, 8'h0f, 8'h7f};

    pll_factor_ctrl #(.AUTO_J(A_J), .AUTO_D(A_D), .AUTO_R(A_R),
        .AUTO_P(A_P), .AUTO_DIV(A_DIV)) pll_factor_ctrl_inst (
        .mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .auto_mode(auto_mode), .pll_j(pll_j),
        .pll_d(pll_d), .pll_r(pll_r), .pll_p(pll_p),
        .dsp_ratio(dsp_ratio), .dsp_clk_en(dsp_clk_en),
        .cfg_illegal(cfg_illegal));

    // Free-running 25 MHz clock
    initial begin
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Strobes are one cycle wide, launched and dropped on falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    // Outputs lag the register by one edge; two falling edges cover it
    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask

    task automatic do_reset();
        @(negedge mclk);
        srst = 1'b1;
        repeat (16) @(negedge mclk);
        srst = 1'b0;
    endtask

    // Outputs leave their reset values one edge after release
    task automatic test_reset();
        settle();
        chk(16'(pll_j), 16'h08);
        chk({pll_d, pll_r[1:0]}, 16'h0001);
        chk({pll_p, dsp_ratio, 2'b00, cfg_illegal}, 16'h0808);
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], v);
            chk(16'(v), 16'(rst[i]));
        end
    endtask

    // All ones everywhere: masked read-back and the top code of J, R, P and the divider
    task automatic test_masks();
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], 8'hff);
            rd(ofs[i], v);
            chk(16'(v), 16'(msk[i]));
        end
        wr(8'h19, 8'hff);
        rd(8'h19, v);
        chk(16'(v), 16'h0000);
        settle();
        chk(16'(pll_j), 16'h3f);
        chk(16'(pll_r), 16'h10);
        chk(16'(dsp_ratio), 16'h80);
        chk({pll_p, 10'h000, cfg_illegal}, 16'h8001);
    endtask

    // D limit at 9999 and one above, then the forbidden zero J
    task automatic test_fraction();
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h01);
        wr(8'h16, 8'h27);
        wr(8'h17, 8'h0f);
        settle();
        chk(16'(pll_d), 16'h270f);
        chk({pll_j, 9'h000, cfg_illegal}, 16'h0400);
        wr(8'h17, 8'h10);
        settle();
        chk({pll_d, 1'b0, cfg_illegal}, 16'h9c41);
        wr(8'h17, 8'h0f);
        wr(8'h15, 8'h00);
        settle();
        chk({pll_j, 9'h000, cfg_illegal}, 16'h0001);
    endtask

    // Auto mode hides the programmed fields, and R and the divider return on leaving it
    task automatic test_auto();
        wr(8'h18, 8'h05);
        wr(8'h1b, 8'h09);
        auto_mode = 1'b1;
        settle();
        chk({pll_j, pll_r, pll_p}, {A_J, A_R, A_P});
        chk(16'(pll_d), 16'(A_D));
        chk({dsp_ratio, 7'h00, cfg_illegal}, {A_DIV, 8'h00});
        auto_mode = 1'b0;
        settle();
        chk({pll_r, dsp_ratio, 2'b00, cfg_illegal}, 16'h3051);
    endtask

    // Pulse spacing for the smallest, two middle and the largest code
    task automatic test_div();
        logic [7:0] code [4] = '{8'h00, 8'h01, 8'h02, 8'h7f};
        int n;
        for (int i = 0; i < 4; i++) begin
            wr(8'h1b, code[i]);
            repeat (300) @(negedge mclk);
            n = 0;
            do begin @(negedge mclk); n++; end
            while (dsp_clk_en !== 1'b1 && n < 300);
            n = 0;
            do begin @(negedge mclk); n++; end
            while (dsp_clk_en !== 1'b1 && n < 300);
            chk(16'(n), 16'(code[i]) + 16'h1);
        end
    endtask

    task automatic end_sim();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence, with a second reset and reset check after the last test
    initial begin
        do_reset();
        test_reset();
        test_masks();
        test_fraction();
        test_auto();
        test_div();
        do_reset();
        test_reset();
        end_sim();
    end

    // Watchdog well beyond the roughly 1600 cycles the tests need
    initial begin
        #(40 * 20000);
        errors++;
        end_sim();
    end
endmodule
